// ---- hdl/acr_params.svh ----
// Register offsets, field positions, reset values and timing counts of the converter result block
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

`define ACR_OFF_RESULT_LOW   8'h78
`define ACR_OFF_RESULT_HIGH  8'h79
`define ACR_OFF_CONTROL_A    8'h7a
`define ACR_OFF_CONTROL_B    8'h7b
`define ACR_OFF_INPUT_SEL    8'h7c
`define ACR_OFF_INPUT_OFF    8'h7e

`define ACR_CA_ENABLE        7
`define ACR_CA_START         6
`define ACR_CA_AUTO          5
`define ACR_CA_DONE          4
`define ACR_CA_INT_EN        3
`define ACR_IS_LEFT          5

`define ACR_CB_WRITE_MASK    8'h07
`define ACR_RESET_BYTE       8'h00

`define ACR_CONV_CYCLES      8'h0d
`define ACR_FIRST_CYCLES     8'h19

`endif

// ---- hdl/acr_pkg.sv ----
// Types shared by the converter result block
package acr_pkg;

  typedef enum logic [2:0] {
    ACR_TRIG_FREE,
    ACR_TRIG_COMPARATOR,
    ACR_TRIG_EXT_IRQ0,
    ACR_TRIG_T0_MATCH,
    ACR_TRIG_T0_OVF,
    ACR_TRIG_MATCH_B,
    ACR_TRIG_T1_OVF,
    ACR_TRIG_T1_CAPTURE
  } acr_trig_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acr_bus_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] value;
  } acr_result_t;

endpackage

// ---- hdl/acr_trigger_edge.sv ----
// Auto-trigger source selection and rising-edge detection
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"

module acr_trigger_edge
  import acr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstSync_b,
  input  wire logic       autoEn,
  input  wire logic       convEnable,
  input  wire acr_trig_t  triggerSourceSel,
  input  wire logic [7:0] sourceFlags,
  output logic            triggerPulse
);

  logic selectedFlag;
  logic prevFlag;
  logic prevFree;

  // Source zero is the done flag; index directly by the select code
  assign selectedFlag = sourceFlags[triggerSourceSel];

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      prevFlag <= 1'b0;
      prevFree <= 1'b1;
    end
    else
    begin
      prevFlag <= selectedFlag;
      prevFree <= (triggerSourceSel == ACR_TRIG_FREE);
    end
  end

  // A switch into free running alone gives no edge
  assign triggerPulse = autoEn && convEnable && selectedFlag && !prevFlag   // R7 R8 R9
                        && !((triggerSourceSel == ACR_TRIG_FREE) && !prevFree); // R10

endmodule
`default_nettype wire

// ---- hdl/acr_converter_result.sv ----
// Converter result pair, alignment, auto-trigger control and input buffer disable
//
// Contract
// R1 - Finished conversion loads ten-bit result pair
// R2 - Low byte read locks pair until high
// R3 - Right aligned: high bits9:8, low bits7:0
// R4 - Left aligned: high bits9:2, low bits1:0 top
// R5 - Software reads low byte before high
// R6 - Software writes zero to control B bit7
// R7 - Trigger field works only with auto enable
// R8 - Rising edge of selected flag starts conversion
// R9 - Switching to set source gives edge
// R10 - Switching to free running gives no trigger
// R11 - Trigger codes map to eight fixed sources
// R12 - Disable bit turns pin buffer off
// R13 - Disabled pin reads zero in pin register
// R14 - Software disables buffers on analog-only pins
// R15 - Result bytes read-only, zero after reset
// R16 - Alignment change re-presents held result immediately
// R17 - Done flag sets when result updates
// R18 - Auto enable bit enables hardware triggers
// R19 - Clearing enable aborts running conversion
// R20 - Result finishing during lock is discarded
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "acr_params.svh"

module acr_converter_result
  import acr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] busAddr,
  input  wire logic [7:0] busWdata,
  input  wire logic       busWr,
  input  wire logic       busRd,
  output logic [7:0]      busRdata,
  input  wire logic [9:0] sampleValue,
  input  wire logic       comparatorFlag,
  input  wire logic       extIrq0Flag,
  input  wire logic       t0MatchFlag,
  input  wire logic       t0OverflowFlag,
  input  wire logic       matchBFlag,
  input  wire logic       t1OverflowFlag,
  input  wire logic       t1CaptureFlag,
  input  wire logic [7:0] padLevel,
  output logic [7:0]      pinInput,
  output logic [7:0]      pinBufferOff,
  output logic            convBusy,
  output logic            convEnableOut
);

  logic        rstMeta_b;
  logic        rstSync_b;
  acr_bus_t    bus;
  acr_result_t done;
  logic [9:0]  heldResult;
  logic        readLock;
  logic        convEnable;
  logic        startReq;
  logic        autoEn;
  logic        doneFlag;
  logic [1:0]  prescaleSel;
  logic        intEnable;
  logic [7:0]  inputSel;
  acr_trig_t   triggerSourceSel;
  logic [7:0]  pinBufferOffBits;
  logic        firstConv;
  logic [7:0]  cycleCount;
  logic        triggerPulse;
  logic [7:0]  sourceFlags;

  logic        leftAlign;
  logic [7:0]  resultHighView;
  logic [7:0]  resultLowView;
  logic [7:0]  controlAView;
  logic [7:0]  controlBView;
  logic [7:0]  next_busRdata;
  logic        wrControlA;
  logic        wrControlB;
  logic        wrInputSel;
  logic        wrInputOff;
  logic        rdLow;
  logic        rdHigh;
  logic        startNow;
  logic        finishNow;
  logic        doneClear;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end
    else
    begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};

  assign wrControlA = bus.wr && (bus.addr == `ACR_OFF_CONTROL_A);
  assign wrControlB = bus.wr && (bus.addr == `ACR_OFF_CONTROL_B);
  assign wrInputSel = bus.wr && (bus.addr == `ACR_OFF_INPUT_SEL);
  assign wrInputOff = bus.wr && (bus.addr == `ACR_OFF_INPUT_OFF);
  assign rdLow      = bus.rd && (bus.addr == `ACR_OFF_RESULT_LOW);
  assign rdHigh     = bus.rd && (bus.addr == `ACR_OFF_RESULT_HIGH);

  assign leftAlign = inputSel[`ACR_IS_LEFT];

  // Views are combinational from the held value, so alignment acts at once
  assign resultHighView = leftAlign ? heldResult[9:2] : {6'h00, heldResult[9:8]};  // R3 R4 R16
  assign resultLowView  = leftAlign ? {heldResult[1:0], 6'h00} : heldResult[7:0];  // R3 R4 R16

  assign controlAView = {convEnable, convBusy, autoEn, doneFlag, intEnable, 1'b0, prescaleSel};
  // Reserved bit 7 and unused bits read zero
  assign controlBView = {5'h00, triggerSourceSel};

  assign next_busRdata =
      (bus.addr == `ACR_OFF_RESULT_LOW)  ? resultLowView :
      (bus.addr == `ACR_OFF_RESULT_HIGH) ? resultHighView :
      (bus.addr == `ACR_OFF_CONTROL_A)   ? controlAView :
      (bus.addr == `ACR_OFF_CONTROL_B)   ? controlBView :
      (bus.addr == `ACR_OFF_INPUT_SEL)   ? inputSel :
      (bus.addr == `ACR_OFF_INPUT_OFF)   ? pinBufferOffBits :
                                           `ACR_RESET_BYTE;

  assign sourceFlags = {t1CaptureFlag, t1OverflowFlag, matchBFlag, t0OverflowFlag,
                        t0MatchFlag, extIrq0Flag, comparatorFlag, doneFlag};  // R11

  acr_trigger_edge u_trigger
  (
    .clk              (clk),
    .rstSync_b        (rstSync_b),
    .autoEn           (autoEn),
    .convEnable       (convEnable),
    .triggerSourceSel (triggerSourceSel),
    .sourceFlags      (sourceFlags),
    .triggerPulse     (triggerPulse)
  );

  assign startNow  = convEnable && !convBusy
                     && (triggerPulse || startReq);  // R8 R18
  assign finishNow = convBusy && convEnable && (cycleCount == 8'h01);
  assign done      = '{valid: finishNow, value: sampleValue};
  assign doneClear = wrControlA && bus.wdata[`ACR_CA_DONE];

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      busRdata <= `ACR_RESET_BYTE;
    else if (bus.rd)
      busRdata <= next_busRdata;
    else
      busRdata <= `ACR_RESET_BYTE;
  end

  // Lock starts on a low read and ends on a high read
  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      readLock <= 1'b0;
    else if (rdHigh)
      readLock <= 1'b0;  // R2
    else if (rdLow)
      readLock <= 1'b1;  // R2
  end

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      heldResult <= 10'h000;  // R15
    else if (done.valid && !readLock)
      heldResult <= done.value;  // R1 R20
  end

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      doneFlag <= 1'b0;
    else if (done.valid && !readLock)
      doneFlag <= 1'b1;  // R17
    else if (doneClear)
      doneFlag <= 1'b0;
  end

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      convEnable  <= 1'b0;
      autoEn      <= 1'b0;
      intEnable   <= 1'b0;
      prescaleSel <= 2'h0;
    end
    else if (wrControlA)
    begin
      convEnable  <= bus.wdata[`ACR_CA_ENABLE];
      autoEn      <= bus.wdata[`ACR_CA_AUTO];  // R18
      intEnable   <= bus.wdata[`ACR_CA_INT_EN];
      prescaleSel <= bus.wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      startReq <= 1'b0;
    else
      startReq <= wrControlA && bus.wdata[`ACR_CA_START] && bus.wdata[`ACR_CA_ENABLE];
  end

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      triggerSourceSel <= ACR_TRIG_FREE;
    else if (wrControlB)
      triggerSourceSel <= acr_trig_t'(3'(bus.wdata & `ACR_CB_WRITE_MASK));
  end

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      inputSel <= `ACR_RESET_BYTE;
    else if (wrInputSel)
      inputSel <= bus.wdata;
  end

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      pinBufferOffBits <= `ACR_RESET_BYTE;
    else if (wrInputOff)
      pinBufferOffBits <= bus.wdata;
  end

  // Conversion timer; the first one after enable is longer
  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
    begin
      convBusy   <= 1'b0;
      cycleCount <= 8'h00;
      firstConv  <= 1'b1;
    end
    else if (!convEnable)
    begin
      convBusy   <= 1'b0;  // R19
      cycleCount <= 8'h00;
      firstConv  <= 1'b1;
    end
    else if (startNow)
    begin
      convBusy   <= 1'b1;
      cycleCount <= firstConv ? `ACR_FIRST_CYCLES : `ACR_CONV_CYCLES;
      firstConv  <= 1'b0;
    end
    else if (convBusy)
    begin
      cycleCount <= cycleCount - 8'h01;
      convBusy   <= !finishNow;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pin
      always_ff @(posedge clk or negedge rstSync_b)
      begin
        if (!rstSync_b)
        begin
          pinInput[gi]     <= 1'b0;
          pinBufferOff[gi] <= 1'b0;
        end
        else
        begin
          pinBufferOff[gi] <= pinBufferOffBits[gi];                          // R12
          pinInput[gi]     <= pinBufferOffBits[gi] ? 1'b0 : padLevel[gi];    // R13
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstSync_b)
  begin
    if (!rstSync_b)
      convEnableOut <= 1'b0;
    else
      convEnableOut <= convEnable;
  end

  property p_lock_blocks;
    @(posedge clk) disable iff (!rstSync_b)
    (readLock && !rdHigh) |=> $stable(heldResult);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("result changed while locked"); // R2

  property p_load;
    @(posedge clk) disable iff (!rstSync_b)
    (finishNow && !readLock) |=> (heldResult == $past(sampleValue)) && doneFlag;
  endproperty
  a_load: assert property (p_load) else $error("result not loaded on finish"); // R1

  property p_discard;
    @(posedge clk) disable iff (!rstSync_b)
    (finishNow && readLock) |=> $stable(heldResult);
  endproperty
  a_discard: assert property (p_discard) else $error("locked result overwritten"); // R20

  property p_right;
    @(posedge clk) disable iff (!rstSync_b)
    (bus.rd && bus.addr == `ACR_OFF_RESULT_HIGH && !leftAlign)
      |=> busRdata == {6'h00, $past(heldResult[9:8])};
  endproperty
  a_right: assert property (p_right) else $error("right aligned high byte wrong"); // R3

  property p_left;
    @(posedge clk) disable iff (!rstSync_b)
    (bus.rd && bus.addr == `ACR_OFF_RESULT_LOW && leftAlign)
      |=> busRdata == {$past(heldResult[1:0]), 6'h00};
  endproperty
  a_left: assert property (p_left) else $error("left aligned low byte wrong"); // R4

  sequence s_went_free;
    triggerSourceSel == ACR_TRIG_FREE && $changed(triggerSourceSel);
  endsequence
  property p_free_switch;
    @(posedge clk) disable iff (!rstSync_b)
    s_went_free |-> !triggerPulse;
  endproperty
  a_free_switch: assert property (p_free_switch) else $error("free-running switch triggered"); // R10

  property p_auto_off;
    @(posedge clk) disable iff (!rstSync_b)
    !autoEn |-> !triggerPulse;
  endproperty
  a_auto_off: assert property (p_auto_off) else $error("trigger while auto disabled"); // R7

  property p_abort;
    @(posedge clk) disable iff (!rstSync_b)
    (wrControlA && !bus.wdata[`ACR_CA_ENABLE]) |=> ##1 !convBusy;
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted"); // R19

  property p_pin_zero;
    @(posedge clk) disable iff (!rstSync_b)
    pinBufferOffBits[0] |=> !pinInput[0];
  endproperty
  a_pin_zero: assert property (p_pin_zero) else $error("disabled pin read nonzero"); // R13

endmodule
`default_nettype wire

// ---- testbench/acr_source_model.sv ----
// Behavioural model of the analog pins and on-chip trigger flag sources
`timescale 1ns/1ps
`default_nettype none

module acr_source_model
(
  input  wire logic       clk,
  input  wire logic [9:0] sampleSet,
  input  wire logic [6:0] flagSet,
  input  wire logic [7:0] padSet,
  output logic [9:0]      sampleValue,
  output logic [6:0]      flags,
  output logic [7:0]      padLevel
);
  // Flags are levels that stay up until their source drops them
  always_ff @(posedge clk)
  begin
    sampleValue <= sampleSet;
    flags       <= flagSet;
    padLevel    <= padSet;
  end
endmodule
`default_nettype wire

// ---- testbench/tb_adc_result_and_autotrigger.sv ----
// Self-checking bench of the converter result block
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end

module tb_adc_result_and_autotrigger;
  logic       clk;
  logic       rst_b;
  logic [7:0] busAddr;
  logic [7:0] busWdata;
  logic       busWr;
  logic       busRd;
  logic [7:0] busRdata;
  logic [9:0] sampleSet;
  logic [9:0] sampleValue;
  logic [6:0] flagSet;
  logic [6:0] flags;
  logic [7:0] padSet;
  logic [7:0] padLevel;
  logic [7:0] pinInput;
  logic [7:0] pinBufferOff;
  logic       convBusy;
  logic       convEnableOut;
  logic [7:0] d;
  logic       b;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         cycles    = 0;

  acr_source_model u_acr_source_model (.clk(clk), .sampleSet(sampleSet), .flagSet(flagSet),
    .padSet(padSet), .sampleValue(sampleValue), .flags(flags), .padLevel(padLevel));

  acr_converter_result u_acr_converter_result (.clk(clk), .rst_b(rst_b), .busAddr(busAddr),
    .busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
    .sampleValue(sampleValue), .comparatorFlag(flags[0]), .extIrq0Flag(flags[1]),
    .t0MatchFlag(flags[2]), .t0OverflowFlag(flags[3]), .matchBFlag(flags[4]),
    .t1OverflowFlag(flags[5]), .t1CaptureFlag(flags[6]), .padLevel(padLevel),
    .pinInput(pinInput), .pinBufferOff(pinBufferOff), .convBusy(convBusy),
    .convEnableOut(convEnableOut));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      wrap_up;
    end
  end

  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    busAddr  <= a;
    busWdata <= v;
    busWr    <= 1'b1;
    @(posedge clk);
    busWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    busAddr <= a;
    busRd   <= 1'b1;
    @(posedge clk);
    busRd <= 1'b0;
    #1;
    v = busRdata;
  endtask

  task automatic pair(input logic [7:0] lo, input logic [7:0] hi);
    rd(8'h78, d);
    `CHK(d, lo)
    rd(8'h79, d);
    `CHK(d, hi)
  endtask

  task automatic idle;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    #1;
    while (convBusy === 1'b1 && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(convBusy, 1'b0)
  endtask

  task automatic seeBusy(input logic e);
    b = 1'b0;
    repeat (5)
    begin
      @(posedge clk);
      #1;
      if (convBusy === 1'b1)
        b = 1'b1;
    end
    `CHK(b, e)
  endtask

  task automatic t_reset;
    pair(8'h00, 8'h00);
    rd(8'h70, d);
    `CHK(d, 8'h00)
    wr(8'h78, 8'hff);
    // Read both bytes so the pair is not left locked
    pair(8'h00, 8'h00);
  endtask

  task automatic t_single;
    sampleSet <= 10'h2a5;
    wr(8'h7a, 8'hc0);
    idle;
    `CHK(convEnableOut, 1'b1)
    pair(8'ha5, 8'h02);
    rd(8'h7a, d);
    `CHK(d[4], 1'b1)
    wr(8'h7a, 8'h90);
  endtask

  task automatic t_align;
    wr(8'h7c, 8'h20);
    pair(8'h40, 8'ha9);
    wr(8'h7c, 8'h00);
    pair(8'ha5, 8'h02);
  endtask

  task automatic t_lock;
    rd(8'h78, d);
    `CHK(d, 8'ha5)
    sampleSet <= 10'h155;
    wr(8'h7a, 8'hc0);
    idle;
    rd(8'h79, d);
    `CHK(d, 8'h02)
    pair(8'ha5, 8'h02);
    rd(8'h7a, d);
    `CHK(d[4], 1'b0)
  endtask

  task automatic t_auto;
    wr(8'h7a, 8'ha0);
    for (int c = 1; c < 8; c++)
    begin
      wr(8'h7b, 8'(c));
      wr(8'h7a, 8'hb0);
      flagSet <= 7'(7'h01 << (c - 1));
      seeBusy(1'b1);
      idle;
      flagSet <= 7'h00;
    end
    wr(8'h7b, 8'h00);
    seeBusy(1'b0);
    flagSet <= 7'h01;
    wr(8'h7b, 8'h02);
    seeBusy(1'b0);
    wr(8'h7b, 8'h01);
    seeBusy(1'b1);
    idle;
    // Free running: the done flag of one conversion starts the next
    wr(8'h7b, 8'h00);
    wr(8'h7a, 8'hf0);
    idle;
    seeBusy(1'b1);
    idle;
  endtask

  task automatic t_manual;
    flagSet <= 7'h00;
    wr(8'h7a, 8'h90);
    wr(8'h7b, 8'h03);
    flagSet <= 7'h04;
    seeBusy(1'b0);
  endtask

  task automatic t_pins;
    padSet <= 8'hff;
    wr(8'h7e, 8'h0f);
    repeat (3) @(posedge clk);
    #1;
    `CHK(pinBufferOff, 8'h0f)
    `CHK(pinInput, 8'hf0)
    rd(8'h7e, d);
    `CHK(d, 8'h0f)
  endtask

  task automatic t_abort;
    wr(8'h7a, 8'hc0);
    repeat (3) @(posedge clk);
    #1;
    `CHK(convBusy, 1'b1)
    wr(8'h7a, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK(convBusy, 1'b0)
    `CHK(convEnableOut, 1'b0)
  endtask

  initial
  begin
    rst_b     = 1'b0;
    busAddr   = 8'h00;
    busWdata  = 8'h00;
    busWr     = 1'b0;
    busRd     = 1'b0;
    sampleSet = 10'h000;
    flagSet   = 7'h00;
    padSet    = 8'h00;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_single;
    t_align;
    t_lock;
    t_auto;
    t_manual;
    t_pins;
    t_abort;
    wrap_up;
  end
endmodule
`default_nettype wire
